// ### design/cefb_flag_bank.sv
// charger event flag bank: three read-to-clear event flag bytes.
// assumes event levels come from charger logic on clk (no sync needed)
// and the serial host interface turns reads into rd_req pulses.
`timescale 1ns/1ns
module cefb_flag_bank
   import cefb_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire cefb_evt_t evt,
   input wire cefb_mask_t mask,
   input wire logic rd_req,
   input wire logic [7:0] rd_addr,
   output logic [7:0] rd_data,
   output logic rd_ack,
   output logic int_n
);
   cefb_state_t s_ff;
   cefb_state_t nxt_s;
   logic [CEFB_NREG-1:0][7:0] lvl;
   logic [CEFB_NREG-1:0][7:0] set;
   logic [CEFB_NREG-1:0][7:0] msk;
   logic [CEFB_NREG-1:0] hit;
   logic [CEFB_NREG-1:0][7:0] rise_m;
   logic [CEFB_NREG-1:0][7:0] both_m;
   logic [CEFB_NREG-1:0][7:0] ofs_m;
   logic adc_set;
   logic pend;

   assign rise_m = {CEFB_RISE_FAULT, CEFB_RISE_THREE, CEFB_RISE_TWO};
   assign both_m = {CEFB_BOTH_FAULT, CEFB_BOTH_THREE, CEFB_BOTH_TWO};
   assign ofs_m = {CEFB_OFS_FAULT, CEFB_OFS_THREE, CEFB_OFS_TWO};
   assign msk = {mask.fault, mask.three, mask.two};

   always_comb begin
      lvl = '0;
      lvl[CEFB_R_TWO][CEFB_B_DET_DONE] = evt.adapter_detect_done;
      lvl[CEFB_R_TWO][CEFB_B_MINSYS] = evt.min_system_reg_active;
      lvl[CEFB_R_TWO][CEFB_B_FAST_TMO] = evt.fast_charge_timeout;
      lvl[CEFB_R_TWO][CEFB_B_TRICKLE_TMO] = evt.trickle_timeout;
      lvl[CEFB_R_TWO][CEFB_B_PRE_TMO] = evt.precharge_timeout;
      lvl[CEFB_R_TWO][CEFB_B_TOPOFF_TMO] = evt.topoff_timeout;
      lvl[CEFB_R_THREE][CEFB_B_BAT_LOW] = evt.battery_low_for_reverse;
      lvl[CEFB_R_THREE][CEFB_B_COLD] = evt.thermistor_beyond_cold;
      lvl[CEFB_R_THREE][CEFB_B_COOL] = evt.thermistor_beyond_cool;
      lvl[CEFB_R_THREE][CEFB_B_WARM] = evt.thermistor_beyond_warm;
      lvl[CEFB_R_THREE][CEFB_B_HOT] = evt.thermistor_beyond_hot;
      lvl[CEFB_R_FAULT][CEFB_B_IBAT_REG] = evt.battery_current_reg_active;
      lvl[CEFB_R_FAULT][CEFB_B_BUS_OVP] = evt.input_bus_overvoltage;
      lvl[CEFB_R_FAULT][CEFB_B_BAT_OVP] = evt.battery_overvoltage;
      lvl[CEFB_R_FAULT][CEFB_B_BUS_OCP] = evt.input_bus_overcurrent;
      lvl[CEFB_R_FAULT][CEFB_B_DIS_OCP] = evt.discharge_overcurrent;
      lvl[CEFB_R_FAULT][CEFB_B_CONV_OCP] = evt.converter_overcurrent;
      lvl[CEFB_R_FAULT][CEFB_B_IN2_OVP] = evt.second_input_overvoltage;
      lvl[CEFB_R_FAULT][CEFB_B_IN1_OVP] = evt.first_input_overvoltage;
   end

   // conversion-done only counts in one-shot mode
   assign adc_set = evt.adc_done & evt.adc_one_shot;

   always_comb begin
      nxt_s = s_ff;
      nxt_s.lvl = lvl;
      nxt_s.rd_data = CEFB_FLAG_RST;
      nxt_s.rd_ack = rd_req;
      for (int i = 0; i < CEFB_NREG; i++) begin
         hit[i] = rd_req && (rd_addr == ofs_m[i]);
         set[i] = (lvl[i] & ~s_ff.lvl[i] & rise_m[i])
            | ((lvl[i] ^ s_ff.lvl[i]) & both_m[i]);
         if (i == CEFB_R_TWO) begin
            set[i][CEFB_B_ADC_DONE] = adc_set;
         end
         if (hit[i]) begin
            nxt_s.rd_data = s_ff.flag[i];
         end
         // a new event in the read cycle survives the clear
         nxt_s.flag[i] = (hit[i] ? CEFB_FLAG_RST : s_ff.flag[i]) | set[i];
      end
      // a detection in progress forces the done flag low and raises no pulse
      if (evt.adapter_detect_busy) begin
         set[CEFB_R_TWO][CEFB_B_DET_DONE] = 1'b0;
         nxt_s.flag[CEFB_R_TWO][CEFB_B_DET_DONE] = 1'b0;
      end
      pend = |(set & ~msk);
      nxt_s.int_n = ~pend;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_ff <= '{lvl: '0, flag: '0, rd_data: CEFB_FLAG_RST, rd_ack: 1'b0, int_n: 1'b1};
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign rd_data = s_ff.rd_data;
   assign rd_ack = s_ff.rd_ack;
   assign int_n = s_ff.int_n;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   logic [7:0] f2;
   logic [7:0] f3;
   logic [7:0] ff0;
   assign f2 = s_ff.flag[CEFB_R_TWO];
   assign f3 = s_ff.flag[CEFB_R_THREE];
   assign ff0 = s_ff.flag[CEFB_R_FAULT];

   det_busy_low_a: assert property (
      evt.adapter_detect_busy |=> !f2[CEFB_B_DET_DONE])
      else $error("detect flag high during detection");

   det_done_set_a: assert property (
      $rose(evt.adapter_detect_done) && !evt.adapter_detect_busy
      |=> f2[CEFB_B_DET_DONE])
      else $error("detect completion not flagged");

   adc_done_a: assert property (
      !f2[CEFB_B_ADC_DONE] ##1 f2[CEFB_B_ADC_DONE]
      |-> $past(evt.adc_done && evt.adc_one_shot))
      else $error("adc flag set without one-shot completion");

   minsys_change_a: assert property (
      $changed(evt.min_system_reg_active) |=> f2[CEFB_B_MINSYS])
      else $error("min-system transition not flagged");

   fast_tmo_a: assert property (
      $rose(evt.fast_charge_timeout) |=> f2[CEFB_B_FAST_TMO])
      else $error("fast-charge expiry not flagged");

   trickle_tmo_a: assert property (
      $rose(evt.trickle_timeout) |=> f2[CEFB_B_TRICKLE_TMO])
      else $error("trickle expiry not flagged");

   pre_tmo_a: assert property (
      $rose(evt.precharge_timeout) |=> f2[CEFB_B_PRE_TMO])
      else $error("pre-charge expiry not flagged");

   topoff_tmo_a: assert property (
      $rose(evt.topoff_timeout) |=> f2[CEFB_B_TOPOFF_TMO])
      else $error("top-off expiry not flagged");

   topoff_fall_a: assert property (
      !f2[CEFB_B_TOPOFF_TMO] && $fell(evt.topoff_timeout)
      |=> !f2[CEFB_B_TOPOFF_TMO])
      else $error("top-off flag set on falling edge");

   bat_low_a: assert property (
      $rose(evt.battery_low_for_reverse) |=> f3[CEFB_B_BAT_LOW])
      else $error("battery low not flagged");

   cold_cross_a: assert property (
      $changed(evt.thermistor_beyond_cold) |=> f3[CEFB_B_COLD])
      else $error("cold crossing not flagged");

   cool_cross_a: assert property (
      $changed(evt.thermistor_beyond_cool) |=> f3[CEFB_B_COOL])
      else $error("cool crossing not flagged");

   warm_cross_a: assert property (
      $changed(evt.thermistor_beyond_warm) |=> f3[CEFB_B_WARM])
      else $error("warm crossing not flagged");

   hot_cross_a: assert property (
      $changed(evt.thermistor_beyond_hot) |=> f3[CEFB_B_HOT])
      else $error("hot crossing not flagged");

   ibat_reg_a: assert property (
      $changed(evt.battery_current_reg_active) |=> ff0[CEFB_B_IBAT_REG])
      else $error("current regulation change not flagged");

   bus_ovp_a: assert property (
      $rose(evt.input_bus_overvoltage) |=> ff0[CEFB_B_BUS_OVP])
      else $error("bus overvoltage not flagged");

   bat_ovp_a: assert property (
      $rose(evt.battery_overvoltage) |=> ff0[CEFB_B_BAT_OVP])
      else $error("battery overvoltage not flagged");

   bus_ocp_a: assert property (
      $rose(evt.input_bus_overcurrent) |=> ff0[CEFB_B_BUS_OCP])
      else $error("bus overcurrent not flagged");

   dis_ocp_a: assert property (
      $rose(evt.discharge_overcurrent) |=> ff0[CEFB_B_DIS_OCP])
      else $error("discharge overcurrent not flagged");

   conv_ocp_a: assert property (
      $rose(evt.converter_overcurrent) |=> ff0[CEFB_B_CONV_OCP])
      else $error("converter overcurrent not flagged");

   in2_ovp_a: assert property (
      $rose(evt.second_input_overvoltage) |=> ff0[CEFB_B_IN2_OVP])
      else $error("second input overvoltage not flagged");

   in1_ovp_a: assert property (
      $rose(evt.first_input_overvoltage) |=> ff0[CEFB_B_IN1_OVP])
      else $error("first input overvoltage not flagged");

   masked_quiet_a: assert property (
      $past(arst_n) && $rose(evt.first_input_overvoltage) && mask.fault[CEFB_B_IN1_OVP]
      && $stable(evt[$bits(cefb_evt_t)-1:1]) && !(evt.adc_done && evt.adc_one_shot)
      |=> int_n)
      else $error("masked event pulsed interrupt");

   int_cause_a: assert property (
      !int_n |-> $past(pend))
      else $error("interrupt pulse without unmasked event");

   unmasked_pulse_a: assert property (
      pend |=> !int_n)
      else $error("unmasked event gave no interrupt pulse");

   read_clear_a: assert property (
      rd_req && rd_addr == CEFB_OFS_FAULT && set[CEFB_R_FAULT] == '0
      |=> ff0 == '0 && rd_ack && rd_data == $past(ff0))
      else $error("fault flags not returned and cleared on read");

   hold_unread_a: assert property (
      f3 != '0 && !(rd_req && rd_addr == CEFB_OFS_THREE)
      |=> (f3 & $past(f3)) == $past(f3))
      else $error("unread flag lost");

   // rise-only sources: a falling level leaves a clear flag clear
   fast_fall_a: assert property (
      !f2[CEFB_B_FAST_TMO] && $fell(evt.fast_charge_timeout)
      |=> !f2[CEFB_B_FAST_TMO])
      else $error("fast-charge flag set on falling edge");

   trickle_fall_a: assert property (
      !f2[CEFB_B_TRICKLE_TMO] && $fell(evt.trickle_timeout)
      |=> !f2[CEFB_B_TRICKLE_TMO])
      else $error("trickle flag set on falling edge");

   pre_fall_a: assert property (
      !f2[CEFB_B_PRE_TMO] && $fell(evt.precharge_timeout)
      |=> !f2[CEFB_B_PRE_TMO])
      else $error("pre-charge flag set on falling edge");

   bat_low_fall_a: assert property (
      !f3[CEFB_B_BAT_LOW] && $fell(evt.battery_low_for_reverse)
      |=> !f3[CEFB_B_BAT_LOW])
      else $error("battery low flag set on recovery");

   bus_ovp_fall_a: assert property (
      !ff0[CEFB_B_BUS_OVP] && $fell(evt.input_bus_overvoltage)
      |=> !ff0[CEFB_B_BUS_OVP])
      else $error("bus overvoltage flag set on exit");

   bat_ovp_fall_a: assert property (
      !ff0[CEFB_B_BAT_OVP] && $fell(evt.battery_overvoltage)
      |=> !ff0[CEFB_B_BAT_OVP])
      else $error("battery overvoltage flag set on exit");

   bus_ocp_fall_a: assert property (
      !ff0[CEFB_B_BUS_OCP] && $fell(evt.input_bus_overcurrent)
      |=> !ff0[CEFB_B_BUS_OCP])
      else $error("bus overcurrent flag set on exit");

   dis_ocp_fall_a: assert property (
      !ff0[CEFB_B_DIS_OCP] && $fell(evt.discharge_overcurrent)
      |=> !ff0[CEFB_B_DIS_OCP])
      else $error("discharge overcurrent flag set on exit");

   conv_ocp_fall_a: assert property (
      !ff0[CEFB_B_CONV_OCP] && $fell(evt.converter_overcurrent)
      |=> !ff0[CEFB_B_CONV_OCP])
      else $error("converter overcurrent flag set on exit");

   in2_ovp_fall_a: assert property (
      !ff0[CEFB_B_IN2_OVP] && $fell(evt.second_input_overvoltage)
      |=> !ff0[CEFB_B_IN2_OVP])
      else $error("second input overvoltage flag set on exit");

   in1_ovp_fall_a: assert property (
      !ff0[CEFB_B_IN1_OVP] && $fell(evt.first_input_overvoltage)
      |=> !ff0[CEFB_B_IN1_OVP])
      else $error("first input overvoltage flag set on exit");

   adc_mode_a: assert property (
      !f2[CEFB_B_ADC_DONE] && !evt.adc_one_shot
      |=> !f2[CEFB_B_ADC_DONE])
      else $error("adc flag set outside one-shot mode");

   det_done_hold_a: assert property (
      f2[CEFB_B_DET_DONE] && !evt.adapter_detect_busy
      && !(rd_req && rd_addr == CEFB_OFS_TWO)
      |=> f2[CEFB_B_DET_DONE])
      else $error("detect flag lost before read");

   rd_ack_a: assert property (
      rd_req |=> rd_ack)
      else $error("read gave no acknowledge");

   idle_data_a: assert property (
      !rd_req |=> !rd_ack && rd_data == CEFB_FLAG_RST)
      else $error("read port active without request");

   unmapped_keep_a: assert property (
      rd_req && rd_addr != CEFB_OFS_TWO && rd_addr != CEFB_OFS_THREE
      && rd_addr != CEFB_OFS_FAULT && !evt.adapter_detect_busy
      |=> rd_data == CEFB_FLAG_RST && (s_ff.flag & $past(s_ff.flag)) == $past(s_ff.flag))
      else $error("unmapped read returned data or cleared flags");

   read_two_a: assert property (
      rd_req && rd_addr == CEFB_OFS_TWO && set[CEFB_R_TWO] == '0
      |=> f2 == '0 && rd_ack && rd_data == $past(f2))
      else $error("charger flags two not returned and cleared on read");

   read_three_a: assert property (
      rd_req && rd_addr == CEFB_OFS_THREE && set[CEFB_R_THREE] == '0
      |=> f3 == '0 && rd_ack && rd_data == $past(f3))
      else $error("charger flags three not returned and cleared on read");

   quiet_hold_a: assert property (
      $past(arst_n) && $stable(evt) && !(evt.adc_done && evt.adc_one_shot) && !rd_req
      |=> $stable(s_ff.flag))
      else $error("flags moved with quiet inputs");

   int_idle_a: assert property (
      $past(arst_n) && $stable(evt) && !(evt.adc_done && evt.adc_one_shot)
      |=> int_n)
      else $error("interrupt pulse with no event");

   all_masked_a: assert property (
      mask == '1 |=> int_n)
      else $error("interrupt pulse with every source masked");
endmodule

// ### shared/cefb_pkg.sv
// charger event flag bank: offsets, field positions, carriers.
// assumes one clock shared with the charger core that drives events.
package cefb_pkg;
   localparam int CEFB_NREG = 3;
   localparam logic [7:0] CEFB_OFS_TWO = 8'h24;
   localparam logic [7:0] CEFB_OFS_THREE = 8'h25;
   localparam logic [7:0] CEFB_OFS_FAULT = 8'h26;
   localparam logic [7:0] CEFB_FLAG_RST = 8'h00;
   // register indices
   localparam int CEFB_R_TWO = 0;
   localparam int CEFB_R_THREE = 1;
   localparam int CEFB_R_FAULT = 2;
   // charger_event_flags_two fields
   localparam int CEFB_B_DET_DONE = 6;
   localparam int CEFB_B_ADC_DONE = 5;
   localparam int CEFB_B_MINSYS = 4;
   localparam int CEFB_B_FAST_TMO = 3;
   localparam int CEFB_B_TRICKLE_TMO = 2;
   localparam int CEFB_B_PRE_TMO = 1;
   localparam int CEFB_B_TOPOFF_TMO = 0;
   // charger_event_flags_three fields
   localparam int CEFB_B_BAT_LOW = 4;
   localparam int CEFB_B_COLD = 3;
   localparam int CEFB_B_COOL = 2;
   localparam int CEFB_B_WARM = 1;
   localparam int CEFB_B_HOT = 0;
   // fault_event_flags_zero fields
   localparam int CEFB_B_IBAT_REG = 7;
   localparam int CEFB_B_BUS_OVP = 6;
   localparam int CEFB_B_BAT_OVP = 5;
   localparam int CEFB_B_BUS_OCP = 4;
   localparam int CEFB_B_DIS_OCP = 3;
   localparam int CEFB_B_CONV_OCP = 2;
   localparam int CEFB_B_IN2_OVP = 1;
   localparam int CEFB_B_IN1_OVP = 0;
   // per register: bits set on a rising level, bits set on any change
   localparam logic [7:0] CEFB_RISE_TWO = 8'h4f;
   localparam logic [7:0] CEFB_BOTH_TWO = 8'h10;
   localparam logic [7:0] CEFB_RISE_THREE = 8'h10;
   localparam logic [7:0] CEFB_BOTH_THREE = 8'h0f;
   localparam logic [7:0] CEFB_RISE_FAULT = 8'h7f;
   localparam logic [7:0] CEFB_BOTH_FAULT = 8'h80;

   typedef struct packed {
      logic adapter_detect_busy;
      logic adapter_detect_done;
      logic adc_done;
      logic adc_one_shot;
      logic min_system_reg_active;
      logic fast_charge_timeout;
      logic trickle_timeout;
      logic precharge_timeout;
      logic topoff_timeout;
      logic battery_low_for_reverse;
      logic thermistor_beyond_cold;
      logic thermistor_beyond_cool;
      logic thermistor_beyond_warm;
      logic thermistor_beyond_hot;
      logic battery_current_reg_active;
      logic input_bus_overvoltage;
      logic battery_overvoltage;
      logic input_bus_overcurrent;
      logic discharge_overcurrent;
      logic converter_overcurrent;
      logic second_input_overvoltage;
      logic first_input_overvoltage;
   } cefb_evt_t;

   typedef struct packed {
      logic [7:0] two;
      logic [7:0] three;
      logic [7:0] fault;
   } cefb_mask_t;

   typedef struct packed {
      logic [CEFB_NREG-1:0][7:0] lvl;
      logic [CEFB_NREG-1:0][7:0] flag;
      logic [7:0] rd_data;
      logic rd_ack;
      logic int_n;
   } cefb_state_t;
endpackage

// ### test/cefb_flag_bank_bench.sv
// self-checking bench for the flag bank: event levels in, reads through the host model.
// assumes single clock, events and reads driven on the falling edge.
`timescale 1ns/1ns
module cefb_flag_bank_bench;
   import cefb_pkg::*;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   cefb_evt_t evt = '0;
   cefb_mask_t mask = '0;
   logic rd_req;
   logic rd_ack;
   logic int_n;
   logic [7:0] rd_addr;
   logic [7:0] rd_data;
   int err_count = 0;
   int checks = 0;

   always #2 clk = ~clk;

   cefb_flag_bank u_cefb_flag_bank (.clk(clk), .arst_n(arst_n), .evt(evt), .mask(mask),
      .rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data), .rd_ack(rd_ack), .int_n(int_n));

   cefb_host_model u_cefb_host_model (.clk(clk), .rd_req(rd_req), .rd_addr(rd_addr),
      .rd_data(rd_data), .rd_ack(rd_ack));

   task automatic report_and_stop();
      if (err_count == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      logic ack;
      u_cefb_host_model.read(a, d, ack);
      check("read ack", {7'h00, ack}, 8'h01);
      check("read data", d, exp);
   endtask

   // one source: rise, read-clear, fall, read again
   task automatic one_bit(input logic [7:0] a, input int b, input int e, input logic both);
      evt[e] = 1'b1;
      @(negedge clk);
      check("int on rise", {7'h00, int_n}, 8'h00);
      rd(a, 8'h01 << b);
      rd(a, 8'h00);
      evt[e] = 1'b0;
      @(negedge clk);
      check("int on fall", {7'h00, int_n}, {7'h00, ~both});
      rd(a, both ? (8'h01 << b) : 8'h00);
   endtask

   initial begin
      repeat (2) @(negedge clk);
      arst_n = 1'b1;
      rd(CEFB_OFS_TWO, CEFB_FLAG_RST);
      rd(CEFB_OFS_THREE, CEFB_FLAG_RST);
      rd(CEFB_OFS_FAULT, CEFB_FLAG_RST);
      // unmapped offset answers with zero
      rd(8'h27, 8'h00);
      for (int i = 0; i < 8; i++) begin
         one_bit(CEFB_OFS_FAULT, i, i, i == 7);
      end
      for (int i = 0; i < 5; i++) begin
         one_bit(CEFB_OFS_THREE, i, 8 + i, i < 4);
      end
      for (int i = 0; i < 5; i++) begin
         one_bit(CEFB_OFS_TWO, i, 13 + i, i == 4);
      end
      // masked event still latches, but no pulse
      mask = '1;
      evt.first_input_overvoltage = 1'b1;
      @(negedge clk);
      check("masked int", {7'h00, int_n}, 8'h01);
      rd(CEFB_OFS_FAULT, 8'h01);
      evt.first_input_overvoltage = 1'b0;
      mask = '0;
      // conversion end counts only in one-shot mode
      evt.adc_one_shot = 1'b1;
      evt.adc_done = 1'b1;
      @(negedge clk);
      evt.adc_done = 1'b0;
      rd(CEFB_OFS_TWO, 8'h20);
      evt.adc_one_shot = 1'b0;
      evt.adc_done = 1'b1;
      @(negedge clk);
      evt.adc_done = 1'b0;
      rd(CEFB_OFS_TWO, 8'h00);
      // detection still running keeps the done flag low
      evt.adapter_detect_busy = 1'b1;
      evt.adapter_detect_done = 1'b1;
      rd(CEFB_OFS_TWO, 8'h00);
      evt.adapter_detect_busy = 1'b0;
      evt.adapter_detect_done = 1'b0;
      @(negedge clk);
      evt.adapter_detect_done = 1'b1;
      rd(CEFB_OFS_TWO, 8'h40);
      evt.adapter_detect_done = 1'b0;
      // reset in mid-run drops a pending flag
      evt.battery_overvoltage = 1'b1;
      @(negedge clk);
      arst_n = 1'b0;
      @(negedge clk);
      evt.battery_overvoltage = 1'b0;
      @(negedge clk);
      arst_n = 1'b1;
      rd(CEFB_OFS_FAULT, CEFB_FLAG_RST);
      report_and_stop();
   end

   // the sequence needs well under 1000 cycles
   initial begin
      #40000;
      err_count++;
      report_and_stop();
   end
endmodule

// ### test/cefb_host_model.sv
// host side of the flag bank: issues one-byte reads and captures the answer.
// assumes the answer stands for one cycle, one cycle after the request edge.
`timescale 1ns/1ns
module cefb_host_model (
   input wire logic clk,
   output logic rd_req,
   output logic [7:0] rd_addr,
   input wire logic [7:0] rd_data,
   input wire logic rd_ack
);
   initial begin
      rd_req = 1'b0;
      rd_addr = 8'h00;
   end

   task automatic read(input logic [7:0] a, output logic [7:0] d, output logic ack);
      @(negedge clk);
      rd_req = 1'b1;
      rd_addr = a;
      @(negedge clk);
      rd_req = 1'b0;
      // park on the inverse so a stale address never looks valid
      rd_addr = ~a;
      ack = rd_ack;
      d = rd_data;
   endtask
endmodule
